//--- common/gpio_pkg.sv
// Functional notes
// [R1] Port reads return live pin levels
// [R2] Any reset sets all direction bits
// [R3] Low port: four pins, upper bits zero
// [R4] Level-select output follows regulation bit
// [R5] High port is full eight bits
// [R6] Sleep entry captures high pins 0-3
// [R7] Pin change while asleep resets device
// [R8] Pin-change wake clears status bit 7
// [R9] Wake enabled when config bit 5 zero
// [R10] High pin 7 wakes on rising level
// [R11] Only input pins can trigger wake
// [R12] Outside keeps sleeping pins at defined levels
// [R13] Direction load: one floats, zero drives
// [R14] Direction registers are write-only
// [R15] Latches hold; inputs are not latched
// [R16] Each pin direction set independently
// [R17] Bit set/clear rewrites whole latch from pins
// [R18] Write at cycle end, read samples start
// [R19] Software spaces write and read of port
// [R20] Sleep compares inputs with captured reference
package gpio_pkg;
  // Register file addresses
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_LOW_PORT = 8'h05;
  localparam logic [7:0] ADDR_HIGH_PORT = 8'h06;
  // Direction-load targets (operand of the direction-load op)
  localparam logic [2:0] DIR_SEL_LOW = 3'h5;
  localparam logic [2:0] DIR_SEL_HIGH = 3'h6;
  localparam logic [2:0] DIR_SEL_CFG = 3'h7;
  // Reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [5:0] CFG_RESET = 6'h3f;
  // Field positions
  localparam int CFG_WAKE_DIS_BIT = 5;
  localparam int CFG_REG_LEVEL_BIT = 3;
  localparam int STATUS_WAKE_FLAG_BIT = 7;
  localparam int LOW_PORT_WIDTH = 4;
  localparam int HIGH_PORT_WIDTH = 8;
  localparam int SLOW_PIN = 7;
  // Register operation kinds
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_WRITE = 2'b01,
    OP_BIT_SET = 2'b10,
    OP_BIT_CLEAR = 2'b11
  } port_op_t;
endpackage

//--- common/wake_if.sv
// Wake comparator signals between the port block and its wake detector
interface wake_if;
  logic sleep_enter; // One-cycle pulse at sleep onset
  logic asleep; // Level while sleeping
  logic enable; // Wake feature enabled
  logic [7:0] pins; // Live high port pins
  logic [7:0] dir; // High port direction
  logic wake; // Wake request pulse
  modport port (output sleep_enter, output asleep, output enable, output pins,
                output dir, input wake);
  modport det (input sleep_enter, input asleep, input enable, input pins,
               input dir, output wake);
endinterface

//--- logic/wake_detect.sv
// Pin-change wake comparator for high pins 0-3 and slow pin 7
module wake_detect
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  wake_if.det w
);
  // All state of the detector
  typedef struct packed {
    logic [3:0] ref_lvl; // Captured reference levels
    logic prev7; // Last seen level of slow pin
    logic wake; // Registered wake request
  } wake_state_t;

  wake_state_t s_q;
  wake_state_t s_d;
  logic [3:0] mismatch;
  logic rise7;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;
    mismatch = '0;
    rise7 = 1'b0;
    // [R6] Capture on sleep entry
    if (w.sleep_enter) begin
      s_d.ref_lvl = w.pins[3:0];
    end
    s_d.prev7 = w.pins[SLOW_PIN];
    // One pulse per wake: hold off while the last request is still out
    if (w.asleep && w.enable && !w.sleep_enter && !s_q.wake) begin
      // [R20] Compare with reference; [R11] inputs only
      mismatch = (w.pins[3:0] ^ s_q.ref_lvl) & w.dir[3:0];
      // [R10] Slow pin rising edge
      rise7 = w.pins[SLOW_PIN] && !s_q.prev7 && w.dir[SLOW_PIN];
      // [R7] Raise the wake reset
      s_d.wake = (|mismatch) || rise7;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign w.wake = s_q.wake;

  // Mismatch on an input pin raises wake next cycle
  property p_wake_on_mismatch;
    @(posedge clk_i) disable iff (sys_rst_i)
      (w.asleep && w.enable && !w.sleep_enter && !w.wake &&
       (|((w.pins[3:0] ^ s_q.ref_lvl) & w.dir[3:0]))) |=> w.wake;
  endproperty
  a_wake_on_mismatch: assert property (p_wake_on_mismatch) // [R20]
    else $error("wake missed on pin mismatch");

  // Disabled feature never wakes
  property p_no_wake_disabled;
    @(posedge clk_i) disable iff (sys_rst_i)
      !$past(w.enable) |-> !w.wake;
  endproperty
  a_no_wake_disabled: assert property (p_no_wake_disabled) // [R9]
    else $error("wake while disabled");

  // Output pins never cause a wake
  property p_outputs_ignored;
    @(posedge clk_i) disable iff (sys_rst_i)
      (w.asleep && w.enable && !w.sleep_enter &&
       (((w.pins[3:0] ^ s_q.ref_lvl) & w.dir[3:0]) == 4'h0) &&
       !(w.dir[SLOW_PIN] && $rose(w.pins[SLOW_PIN]))) |=> !w.wake;
  endproperty
  a_outputs_ignored: assert property (p_outputs_ignored) // [R11]
    else $error("wake from output pin");

  // Slow pin rise wakes
  property p_slow_rise;
    @(posedge clk_i) disable iff (sys_rst_i)
      (w.asleep && w.enable && !w.sleep_enter && !w.wake && w.dir[SLOW_PIN] &&
       $rose(w.pins[SLOW_PIN])) |=> w.wake;
  endproperty
  a_slow_rise: assert property (p_slow_rise) // [R10]
    else $error("slow pin rise did not wake");
endmodule // wake_detect

//--- logic/gpio_port.sv
// Dual GPIO port with pin-change wake
module gpio_port
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cycle_end_i, // Instruction-cycle end strobe
  input wire logic [7:0] addr_i, // Register address
  input wire port_op_t op_i, // Operation on addressed port
  input wire logic [2:0] bit_sel_i, // Bit for set/clear
  input wire logic [7:0] wdata_i, // Working-register data
  input wire logic dir_load_i, // Direction-load strobe
  input wire logic [2:0] dir_sel_i, // Direction-load target
  input wire logic sleep_i, // Sleep instruction strobe
  input wire logic [3:0] low_pins_i, // Low port pin levels
  input wire logic [7:0] high_pins_i, // High port pin levels
  output logic [7:0] rdata_o, // Read data
  output logic [3:0] low_pins_o, // Low port drive values
  output logic [3:0] low_pins_oe_o, // Low port enables
  output logic [7:0] high_pins_o, // High port drive values
  output logic [7:0] high_pins_oe_o, // High port enables
  output logic regulation_level_select_o, // 1 = 5 V, 0 = 3 V pads
  output logic wake_reset_o, // Wake reset pulse to core
  output logic pin_change_wake_flag_o // Status bit 7
);
  // All state of the port block
  typedef struct packed {
    logic [3:0] low_latch;
    logic [7:0] high_latch;
    logic [3:0] low_port_direction;
    logic [7:0] high_port_direction;
    logic [5:0] cfg;
    logic asleep;
    logic wake_flag;
    logic [3:0] low_samp; // Pins sampled at cycle start
    logic [7:0] high_samp;
    logic [7:0] rdata;
    logic wake_rst;
  } port_state_t;

  port_state_t s_q;
  port_state_t s_d;
  wake_if w();

  // Apply set/clear or plain write to a value read from pins
  function automatic logic [7:0] modify(input port_op_t op, input logic [7:0] pins,
                                        input logic [2:0] b, input logic [7:0] wd);
    logic [7:0] r;
    r = pins;
    case (op)
      OP_WRITE: r = wd;
      OP_BIT_SET: r[b] = 1'b1;
      OP_BIT_CLEAR: r[b] = 1'b0;
      default: r = pins;
    endcase
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.wake_rst = 1'b0;
    // [R18] Sample pins at cycle start; [R15] no input latch
    if (cycle_end_i) begin
      s_d.low_samp = low_pins_i;
      s_d.high_samp = high_pins_i;
    end
    // [R1] Reads return pins; [R3] upper low bits zero
    case (addr_i)
      ADDR_LOW_PORT: s_d.rdata = {4'h0, s_q.low_samp};
      ADDR_HIGH_PORT: s_d.rdata = s_q.high_samp; // [R5] all eight pins
      ADDR_STATUS: s_d.rdata = {s_q.wake_flag, 7'h00};
      default: s_d.rdata = 8'h00;
    endcase
    // [R17] Read-modify-write from pins; [R18] commits at cycle end
    if (cycle_end_i && op_i != OP_NONE) begin
      if (addr_i == ADDR_LOW_PORT) begin
        s_d.low_latch = 4'(modify(op_i, {4'h0, s_q.low_samp}, bit_sel_i, wdata_i));
      end else if (addr_i == ADDR_HIGH_PORT) begin
        s_d.high_latch = modify(op_i, s_q.high_samp, bit_sel_i, wdata_i);
      end
    end
    // [R13] Direction load; [R16] per bit; [R14] no read path
    if (dir_load_i) begin
      case (dir_sel_i)
        DIR_SEL_LOW: s_d.low_port_direction = wdata_i[3:0];
        DIR_SEL_HIGH: s_d.high_port_direction = wdata_i;
        DIR_SEL_CFG: s_d.cfg = wdata_i[5:0];
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    if (sleep_i) begin
      s_d.asleep = 1'b1;
    end
    // [R7] Wake resets device; [R8] flag cleared, [R2] directions set
    if (w.wake) begin
      s_d.asleep = 1'b0;
      s_d.wake_flag = 1'b0;
      s_d.wake_rst = 1'b1;
      s_d.low_port_direction = DIR_RESET[3:0];
      s_d.high_port_direction = DIR_RESET;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // [R2] Reset sets all direction bits
      s_q <= '0;
      s_q.low_port_direction <= DIR_RESET[3:0];
      s_q.high_port_direction <= DIR_RESET;
      s_q.cfg <= CFG_RESET;
      s_q.wake_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Elaboration guard: the pin maps here are fixed at four and eight bits
  if (LOW_PORT_WIDTH != 4 || HIGH_PORT_WIDTH != 8 ||
      SLOW_PIN >= HIGH_PORT_WIDTH) begin : g_width_check
    $error("port widths not served by this logic");
  end

  // Wake detector connections
  assign w.sleep_enter = sleep_i && !s_q.asleep;
  assign w.asleep = s_q.asleep;
  // [R9] Enabled when wake-disable bit is zero
  assign w.enable = !s_q.cfg[CFG_WAKE_DIS_BIT];
  assign w.pins = high_pins_i;
  assign w.dir = s_q.high_port_direction;

  wake_detect wake_detect_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .w(w.det)
  );

  // Outputs straight from state
  assign rdata_o = s_q.rdata;
  assign low_pins_o = s_q.low_latch;
  assign low_pins_oe_o = ~s_q.low_port_direction;
  assign high_pins_o = s_q.high_latch;
  assign high_pins_oe_o = ~s_q.high_port_direction;
  // [R4] Pad level select
  assign regulation_level_select_o = s_q.cfg[CFG_REG_LEVEL_BIT];
  assign wake_reset_o = s_q.wake_rst;
  assign pin_change_wake_flag_o = s_q.wake_flag;

  // Directions all set right after reset
  property p_dir_reset;
    @(posedge clk_i) $fell(sys_rst_i) |-> (high_pins_oe_o == 8'h00 && low_pins_oe_o == 4'h0);
  endproperty
  a_dir_reset: assert property (p_dir_reset) // [R2]
    else $error("pins not floating after reset");

  // Low port upper bits read zero
  property p_low_upper_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      (addr_i == ADDR_LOW_PORT) |=> (rdata_o[7:4] == 4'h0);
  endproperty
  a_low_upper_zero: assert property (p_low_upper_zero) // [R3]
    else $error("low port upper bits not zero");

  // High port read returns sampled pins
  property p_read_pins;
    @(posedge clk_i) disable iff (sys_rst_i)
      (addr_i == ADDR_HIGH_PORT) |=> (rdata_o == $past(s_q.high_samp));
  endproperty
  a_read_pins: assert property (p_read_pins) // [R1]
    else $error("read not from pins");

  // Wake reset clears the flag
  property p_wake_clears_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
      wake_reset_o |-> !pin_change_wake_flag_o;
  endproperty
  a_wake_clears_flag: assert property (p_wake_clears_flag) // [R8]
    else $error("wake flag not cleared");

  // Level select tracks config
  property p_level_sel;
    @(posedge clk_i) disable iff (sys_rst_i)
      (dir_load_i && dir_sel_i == DIR_SEL_CFG && !w.wake) |=>
        (regulation_level_select_o == $past(wdata_i[CFG_REG_LEVEL_BIT]));
  endproperty
  a_level_sel: assert property (p_level_sel) // [R4]
    else $error("level select mismatch");

  // Direction load drives enables
  property p_dir_load;
    @(posedge clk_i) disable iff (sys_rst_i)
      (dir_load_i && dir_sel_i == DIR_SEL_HIGH && !w.wake) |=>
        (high_pins_oe_o == ~$past(wdata_i));
  endproperty
  a_dir_load: assert property (p_dir_load) // [R13]
    else $error("direction load wrong");

  // Latch holds without a write
  property p_latch_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !(cycle_end_i && op_i != OP_NONE) |=> $stable(high_pins_o) && $stable(low_pins_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [R15]
    else $error("latch changed without write");

  // Bit set writes pin image with bit set
  property p_bit_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      (cycle_end_i && op_i == OP_BIT_SET && addr_i == ADDR_HIGH_PORT) |=>
        (high_pins_o == ($past(s_q.high_samp) | (8'h01 << $past(bit_sel_i))));
  endproperty
  a_bit_set: assert property (p_bit_set) // [R17]
    else $error("bit set result wrong");

  // Bit clear writes pin image with bit cleared
  property p_bit_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      (cycle_end_i && op_i == OP_BIT_CLEAR && addr_i == ADDR_HIGH_PORT) |=>
        (high_pins_o == ($past(s_q.high_samp) & ~(8'h01 << $past(bit_sel_i))));
  endproperty
  a_bit_clear: assert property (p_bit_clear) // [R17]
    else $error("bit clear result wrong");

  // Low port bit clear works on the low pin image
  property p_low_bit_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      (cycle_end_i && op_i == OP_BIT_CLEAR && addr_i == ADDR_LOW_PORT) |=>
        (low_pins_o == ($past(s_q.low_samp) & ~(4'h1 << $past(bit_sel_i))));
  endproperty
  a_low_bit_clear: assert property (p_low_bit_clear) // [R17]
    else $error("low bit clear result wrong");

  // Plain write lands in the high latch at cycle end
  property p_high_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      (cycle_end_i && op_i == OP_WRITE && addr_i == ADDR_HIGH_PORT) |=>
        (high_pins_o == $past(wdata_i));
  endproperty
  a_high_write: assert property (p_high_write) // [R18]
    else $error("high latch write wrong");

  // Plain write keeps the low four data bits
  property p_low_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      (cycle_end_i && op_i == OP_WRITE && addr_i == ADDR_LOW_PORT) |=>
        (low_pins_o == $past(wdata_i[3:0]));
  endproperty
  a_low_write: assert property (p_low_write) // [R15]
    else $error("low latch write wrong");

  // Low direction load drives low enables
  property p_low_dir_load;
    @(posedge clk_i) disable iff (sys_rst_i)
      (dir_load_i && dir_sel_i == DIR_SEL_LOW && !w.wake) |=>
        (low_pins_oe_o == ~$past(wdata_i[3:0]));
  endproperty
  a_low_dir_load: assert property (p_low_dir_load) // [R16]
    else $error("low direction load wrong");

  // Wake reset floats every pin
  property p_wake_floats_pins;
    @(posedge clk_i) disable iff (sys_rst_i)
      w.wake |=> (high_pins_oe_o == 8'h00 && low_pins_oe_o == 4'h0);
  endproperty
  a_wake_floats_pins: assert property (p_wake_floats_pins) // [R2]
    else $error("pins not floating after wake");

  // Wake reset lasts one cycle
  property p_wake_pulse_single;
    @(posedge clk_i) disable iff (sys_rst_i)
      wake_reset_o |=> !wake_reset_o;
  endproperty
  a_wake_pulse_single: assert property (p_wake_pulse_single) // [R7]
    else $error("wake reset longer than one cycle");

  // Wake reset ends sleep
  property p_wake_ends_sleep;
    @(posedge clk_i) disable iff (sys_rst_i)
      wake_reset_o |-> !s_q.asleep;
  endproperty
  a_wake_ends_sleep: assert property (p_wake_ends_sleep) // [R7]
    else $error("still asleep after wake");

  // Flag only falls with a wake reset
  property p_flag_fall_on_wake;
    @(posedge clk_i) disable iff (sys_rst_i)
      $fell(pin_change_wake_flag_o) |-> wake_reset_o;
  endproperty
  a_flag_fall_on_wake: assert property (p_flag_fall_on_wake) // [R8]
    else $error("wake flag fell without wake");

  // Low port read returns sampled pins
  property p_low_read_pins;
    @(posedge clk_i) disable iff (sys_rst_i)
      (addr_i == ADDR_LOW_PORT) |=> (rdata_o == {4'h0, $past(s_q.low_samp)});
  endproperty
  a_low_read_pins: assert property (p_low_read_pins) // [R1]
    else $error("low read not from pins");

  // Status read shows the flag in bit 7
  property p_status_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      (addr_i == ADDR_STATUS) |=> (rdata_o == {$past(pin_change_wake_flag_o), 7'h00});
  endproperty
  a_status_read: assert property (p_status_read) // [R8]
    else $error("status read wrong");

  // Pin samples move only at cycle end
  property p_sample_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      !cycle_end_i |=> ($stable(s_q.high_samp) && $stable(s_q.low_samp));
  endproperty
  a_sample_hold: assert property (p_sample_hold) // [R18]
    else $error("pin sample moved mid cycle");
endmodule // gpio_port

//--- verif/pin_partner.sv
// Outside circuit on both ports, resolving each wire from both drivers
module pin_partner (
  input wire logic [3:0] ext_low_i, // Level applied from outside
  input wire logic [7:0] ext_high_i, // Level applied from outside
  input wire logic [3:0] low_drv_i, // Device drive values
  input wire logic [3:0] low_oe_i, // Device enables
  input wire logic [7:0] high_drv_i, // Device drive values
  input wire logic [7:0] high_oe_i, // Device enables
  output logic [3:0] low_pins_o, // Resolved low wires
  output logic [7:0] high_pins_o // Resolved high wires
);
  timeunit 1ns;
  timeprecision 1ps;
  // Firm sleeping levels
  // Outside never floats a pin, so a sleeping reference stays valid
  assign low_pins_o = (low_oe_i & low_drv_i) | (~low_oe_i & ext_low_i);
  assign high_pins_o = (high_oe_i & high_drv_i) | (~high_oe_i & ext_high_i);
endmodule // pin_partner

//--- verif/dual_port_gpio_pin_wake_test.sv
// Self-checking bench: a driver notes results, a monitor compares them
module dual_port_gpio_pin_wake_test
  import gpio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // One pending comparison
  typedef struct {string nm; int sel; logic [7:0] exp;} note_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cycle_end_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  port_op_t op_i = OP_NONE;
  logic [2:0] bit_sel_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic dir_load_i = 1'b0;
  logic [2:0] dir_sel_i = 3'h0;
  logic sleep_i = 1'b0;
  logic [3:0] ext_low = 4'h0; // Outside levels
  logic [7:0] ext_high = 8'h00;
  logic [3:0] low_pins_i, low_pins_o, low_pins_oe_o;
  logic [7:0] high_pins_i, high_pins_o, high_pins_oe_o, rdata_o;
  logic regulation_level_select_o, wake_reset_o, pin_change_wake_flag_o;
  note_t notes[$]; // Expected results, oldest first
  event result_ev;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'h2594;
  logic [7:0] lat_h, dir_h, d, h; // Bench copy of the high latch and direction
  logic [3:0] l; // Random outside level for the low port
  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;
  gpio_port gpio_port_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cycle_end_i(cycle_end_i),
    .addr_i(addr_i), .op_i(op_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i),
    .dir_load_i(dir_load_i), .dir_sel_i(dir_sel_i), .sleep_i(sleep_i),
    .low_pins_i(low_pins_i), .high_pins_i(high_pins_i), .rdata_o(rdata_o),
    .low_pins_o(low_pins_o), .low_pins_oe_o(low_pins_oe_o), .high_pins_o(high_pins_o),
    .high_pins_oe_o(high_pins_oe_o), .regulation_level_select_o(regulation_level_select_o),
    .wake_reset_o(wake_reset_o), .pin_change_wake_flag_o(pin_change_wake_flag_o));
  pin_partner pin_partner_inst (.ext_low_i(ext_low), .ext_high_i(ext_high),
    .low_drv_i(low_pins_o), .low_oe_i(low_pins_oe_o), .high_drv_i(high_pins_o),
    .high_oe_i(high_pins_oe_o), .low_pins_o(low_pins_i), .high_pins_o(high_pins_i));
  // Wire level seen by the device: inputs follow outside, outputs the latch
  function automatic logic [7:0] lvl(input logic [7:0] dr, input logic [7:0] lt);
    return (~dr & lt) | (dr & ext_high);
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Outputs are settled by the falling edge, so notes are posted there
  task automatic chk(input string nm, input int sel, input logic [7:0] exp);
    @(negedge clk_i);
    notes.push_back('{nm, sel, exp});
    -> result_ev;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic set_ext(input logic [7:0] h, input logic [3:0] l);
    @(posedge clk_i);
    ext_high <= h;
    ext_low <= l;
  endtask
  // One instruction cycle with an optional port operation
  task automatic op(input logic [7:0] a, input port_op_t o, input logic [2:0] b,
                    input logic [7:0] wd);
    @(posedge clk_i);
    addr_i <= a;
    op_i <= o;
    bit_sel_i <= b;
    wdata_i <= wd;
    cycle_end_i <= 1'b1;
    @(posedge clk_i);
    cycle_end_i <= 1'b0;
    op_i <= OP_NONE;
  endtask
  // Reads keep clear of a just-written port
  // Read waits two idle cycles so the sample has reached the read data
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    op(a, OP_NONE, 3'h0, 8'h00);
    cyc(2);
    chk("rdata_o", 0, exp);
  endtask
  task automatic dl(input logic [2:0] s, input logic [7:0] wd);
    @(posedge clk_i);
    dir_load_i <= 1'b1;
    dir_sel_i <= s;
    wdata_i <= wd;
    @(posedge clk_i);
    dir_load_i <= 1'b0;
  endtask
  task automatic slp();
    @(posedge clk_i);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    sleep_i <= 1'b0;
  endtask
  // Bounded wait for the wake pulse; running out ends the run
  task automatic wait_wake();
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (wake_reset_o === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("ERROR wake_reset_o expected 1 seen 0");
      give_verdict();
    end
  endtask
  // Monitor: takes the oldest note for each posted result
  initial begin
    note_t n;
    logic [7:0] seen;
    forever begin
      @(result_ev);
      n = notes.pop_front();
      case (n.sel)
        0: seen = rdata_o;
        1: seen = high_pins_o;
        2: seen = high_pins_oe_o;
        3: seen = {4'h0, low_pins_oe_o};
        4: seen = {7'h00, pin_change_wake_flag_o};
        5: seen = {7'h00, regulation_level_select_o};
        6: seen = {4'h0, low_pins_o};
        default: seen = {7'h00, wake_reset_o};
      endcase
      tests_run++;
      if (seen !== n.exp) begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", n.nm, n.exp, seen);
      end
    end
  end
  // Main sequence
  initial begin
    cyc(10);
    sys_rst_i <= 1'b0;
    chk("high_pins_oe_o", 2, 8'h00);
    chk("low_pins_oe_o", 3, 8'h00);
    chk("level_select", 5, 8'h01);
    rd(ADDR_STATUS, 8'h80);
    dir_h = 8'hff;
    lat_h = 8'h00;
    for (int k = 0; k < 3; k++) begin
      h = 8'($random(seed));
      l = 4'($random(seed));
      set_ext(h, l);
      rd(ADDR_HIGH_PORT, h);
      rd(ADDR_LOW_PORT, {4'h0, l});
    end
    dir_h = 8'h0f;
    dl(DIR_SEL_HIGH, dir_h);
    chk("high_pins_oe_o", 2, 8'hf0);
    dl(DIR_SEL_LOW, 8'h05);
    chk("low_pins_oe_o", 3, 8'h0a);
    lat_h = 8'($random(seed));
    op(ADDR_HIGH_PORT, OP_WRITE, 3'h0, lat_h);
    rd(ADDR_HIGH_PORT, lvl(dir_h, lat_h));
    chk("high_pins_o", 1, lat_h);
    d = 8'($random(seed));
    op(ADDR_LOW_PORT, OP_WRITE, 3'h0, d);
    chk("low_pins_o", 6, {4'h0, d[3:0]});
    rd(ADDR_LOW_PORT, {4'h0, (4'ha & d[3:0]) | (4'h5 & ext_low)});
    // New outside level is sampled by the low clear, before the high set
    h = 8'($random(seed));
    set_ext(h, ext_low);
    op(ADDR_LOW_PORT, OP_BIT_CLEAR, 3'h3, 8'h00);
    chk("low_pins_o", 6, {4'h0, ((4'ha & d[3:0]) | (4'h5 & ext_low)) & 4'h7});
    op(ADDR_HIGH_PORT, OP_BIT_SET, 3'h2, 8'h00);
    lat_h = lvl(dir_h, lat_h) | 8'h04;
    chk("high_pins_o", 1, lat_h);
    op(ADDR_HIGH_PORT, OP_BIT_CLEAR, 3'h6, 8'h00);
    lat_h = lvl(dir_h, lat_h) & 8'hbf;
    chk("high_pins_o", 1, lat_h);
    dl(DIR_SEL_CFG, 8'h17);
    chk("level_select", 5, 8'h00);
    slp();
    repeat (4) chk("wake_reset_o", 7, 8'h00);
    // Pin 7 is an output here: toggling its latch must not wake
    lat_h = lat_h & 8'h7f;
    op(ADDR_HIGH_PORT, OP_WRITE, 3'h0, lat_h);
    op(ADDR_HIGH_PORT, OP_WRITE, 3'h0, lat_h | 8'h80);
    repeat (4) chk("wake_reset_o", 7, 8'h00);
    set_ext(ext_high ^ 8'h02, ext_low);
    wait_wake();
    chk("wake_flag", 4, 8'h00);
    chk("high_pins_oe_o", 2, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    set_ext(ext_high & 8'h7f, ext_low);
    slp();
    repeat (4) chk("wake_reset_o", 7, 8'h00);
    set_ext(ext_high | 8'h80, ext_low);
    wait_wake();
    dl(DIR_SEL_CFG, 8'h37);
    slp();
    set_ext(ext_high ^ 8'h01, ext_low);
    repeat (6) chk("wake_reset_o", 7, 8'h00);
    give_verdict();
  end
endmodule // dual_port_gpio_pin_wake_test
